/* File: rtl/rtd_modbus_regs.sv */
// Purpose: register bank and led sub-functions of the rtd module
// Assumes: framer hands over one register per request, crc checked
// Notes: analog path feeds adcValue and range flags on ref_clk
`timescale 1ns/100ps
module rtd_modbus_regs
  import rtd_pkg::*;
#(
  parameter int MS_CYC_P = MS_CYC,
  parameter int WDT_CYC_P = WDT_UNIT_CYC,
  parameter int CAL_CYC_P = CAL_CYC,
  parameter logic [15:0] FW_LO = 16'h0a01, // arbitrary
  parameter logic [15:0] FW_HI = 16'h0000, // arbitrary
  parameter logic [15:0] NAME_LO = 16'h1234, // arbitrary
  parameter logic [15:0] NAME_HI = 16'h0000 // arbitrary
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic reqValid,
  input wire rtd_req_t req,
  output logic reqReady,
  output logic rspValid,
  output rtd_rsp_t rsp,
  input wire logic [NCH-1:0][15:0] adcValue,
  input wire logic [NCH-1:0] overRange,
  input wire logic [NCH-1:0] underRange,
  input wire logic [NCH-1:0] openWire,
  output rtd_cfg_t cfg,
  output logic calBusy,
  output logic wdtTimeout
);
  function automatic logic inBank(input logic [15:0] a,
                                  input logic [15:0] b);
    inBank = (a >= b) && (a < b + 16'(NCH));
  endfunction
  function automatic logic [2:0] bankIdx(input logic [15:0] a,
                                         input logic [15:0] b);
    logic [15:0] d;
    d = a - b;
    bankIdx = d[2:0];
  endfunction
  rtd_state_t state_r;
  logic [31:0] waitCnt_r;
  rtd_rsp_t rsp_r, rspNxt;
  logic proto_r, filter_r, wdtMode_r, wdtEn_r, format_r;
  logic wdtFlag_r, firstRead_r, openForce_r, fired_r, calBusy_r;
  logic [15:0] station_r, serial_r, delay_r, wdtVal_r, chEn_r;
  logic [15:0] wdtCnt_r, rdData;
  logic [7:0] ledChan_r, ledFmt_r, units_r, excCode;
  logic [15:0] typeCode_r [NCH], tempOfs_r [NCH], resOfs_r [NCH];
  logic [31:0] tick_r, calCnt_r;
  logic [NCH-1:0][15:0] repVal;
  logic [NCH-1:0] statBit;
  wire logic [15:0] reqAddr = req.addr;
  wire logic [15:0] reqData = req.data;
  // per-channel reported value and range status
  for (genvar g = 0; g < NCH; g++) begin : g_chan
    assign repVal[g] = (openWire[g] && openForce_r) ? VAL_OVER :
                       underRange[g] ? VAL_UNDER :
                       overRange[g] ? VAL_OVER : adcValue[g];
    assign statBit[g] = overRange[g] | underRange[g];
  end
  // coil read decode
  wire logic coilHit = inBank(reqAddr, A_OVR_COIL) ||
    reqAddr == A_PROTO || reqAddr == A_FILTER ||
    reqAddr == A_WDT_MODE || reqAddr == A_WDT_EN ||
    reqAddr == A_FORMAT || reqAddr == A_WDT_FLAG ||
    reqAddr == A_FIRST || reqAddr == A_OPEN_FORCE;
  wire logic coilRd =
    inBank(reqAddr, A_OVR_COIL) ? statBit[bankIdx(reqAddr, A_OVR_COIL)] :
    reqAddr == A_PROTO ? proto_r :
    reqAddr == A_FILTER ? filter_r :
    reqAddr == A_WDT_MODE ? wdtMode_r :
    reqAddr == A_WDT_EN ? wdtEn_r :
    reqAddr == A_FORMAT ? format_r :
    reqAddr == A_WDT_FLAG ? wdtFlag_r :
    reqAddr == A_FIRST ? firstRead_r : openForce_r;
  // coil write decode; status and reset coils stay read-only
  wire logic coilWrHit = reqAddr == A_PROTO || reqAddr == A_FILTER ||
    reqAddr == A_WDT_MODE || reqAddr == A_WDT_EN ||
    reqAddr == A_FORMAT || reqAddr == A_WDT_FLAG ||
    reqAddr == A_CAL || reqAddr == A_OPEN_FORCE;
  wire logic coilOn = reqData == COIL_ON;
  wire logic coilValOk = coilOn || reqData == COIL_OFF;
  // holding register read decode
  wire logic holdWrScalar = reqAddr == A_STATION ||
    reqAddr == A_SERIAL || reqAddr == A_DELAY ||
    reqAddr == A_WDT_VAL || reqAddr == A_CH_EN || reqAddr == A_WDT_CNT;
  wire logic holdHit = inBank(reqAddr, A_AIN_MIRROR) ||
    inBank(reqAddr, A_TYPE) || inBank(reqAddr, A_TEMP_OFS) ||
    inBank(reqAddr, A_RES_OFS) || reqAddr == A_FW_LO ||
    reqAddr == A_FW_HI || reqAddr == A_NAME_LO ||
    reqAddr == A_NAME_HI || holdWrScalar;
  wire logic [15:0] holdRd =
    inBank(reqAddr, A_AIN_MIRROR) ?
      repVal[bankIdx(reqAddr, A_AIN_MIRROR)] :
    inBank(reqAddr, A_TYPE) ? typeCode_r[bankIdx(reqAddr, A_TYPE)] :
    inBank(reqAddr, A_TEMP_OFS) ?
      tempOfs_r[bankIdx(reqAddr, A_TEMP_OFS)] :
    inBank(reqAddr, A_RES_OFS) ? resOfs_r[bankIdx(reqAddr, A_RES_OFS)] :
    reqAddr == A_FW_LO ? FW_LO : reqAddr == A_FW_HI ? FW_HI :
    reqAddr == A_NAME_LO ? NAME_LO : reqAddr == A_NAME_HI ? NAME_HI :
    reqAddr == A_STATION ? station_r : reqAddr == A_SERIAL ? serial_r :
    reqAddr == A_DELAY ? delay_r : reqAddr == A_WDT_VAL ? wdtVal_r :
    reqAddr == A_CH_EN ? chEn_r : wdtCnt_r;
  // holding write decode and range checks
  wire logic holdWrHit = inBank(reqAddr, A_TYPE) ||
    inBank(reqAddr, A_TEMP_OFS) || inBank(reqAddr, A_RES_OFS) ||
    holdWrScalar;
  wire logic byteOk = reqData <= BYTE_MAX;
  wire logic sbyteOk = &reqData[15:7] || ~|reqData[15:7];
  wire logic baudOk = reqData[15:8] == 8'h00 &&
    reqData[SER_BAUD_MSB:0] >= BAUD_MIN &&
    reqData[SER_BAUD_MSB:0] <= BAUD_MAX;
  wire logic holdWrOk =
    inBank(reqAddr, A_TEMP_OFS) ? sbyteOk :
    inBank(reqAddr, A_RES_OFS) ? byteOk :
    inBank(reqAddr, A_TYPE) ? byteOk :
    reqAddr == A_STATION ?
      (reqData >= STATION_MIN && reqData <= STATION_MAX) :
    reqAddr == A_SERIAL ? baudOk :
    reqAddr == A_DELAY ? reqData <= DELAY_MAX :
    reqAddr == A_WDT_VAL ? byteOk :
    reqAddr == A_CH_EN ? reqData <= CH_EN_MAX :
    reqData == 16'h0000;
  wire logic multiBad = req.func == FN_WR_MULTI &&
    (req.qty > MAX_WR_REGS || req.qty == 8'h00);
  wire logic ledWrOk = req.nbytes == LED_WR_LEN &&
    reqData[15:8] <= LED_CH_MAX && reqData[7:0] <= LED_FMT_MAX;
  // request decode into answer data or exception code
  always_comb begin
    excCode = 8'h00;
    rdData = 16'h0000;
    unique case (req.func)
      FN_RD_COILS: if (coilHit) rdData = {15'h0000, coilRd};
        else excCode = EXC_ADDR;
      FN_RD_INPUTS: if (inBank(reqAddr, A_OVR_INPUT))
          rdData = {15'h0000, statBit[bankIdx(reqAddr, A_OVR_INPUT)]};
        else excCode = EXC_ADDR;
      FN_RD_HOLD: if (holdHit) rdData = holdRd;
        else excCode = EXC_ADDR;
      FN_RD_INREG: if (inBank(reqAddr, A_AIN))
          rdData = repVal[bankIdx(reqAddr, A_AIN)];
        else excCode = EXC_ADDR;
      FN_WR_COIL: if (!coilWrHit) excCode = EXC_ADDR;
        else if (!coilValOk) excCode = EXC_DATA;
        else rdData = reqData;
      FN_WR_REG, FN_WR_MULTI: if (multiBad) excCode = EXC_DATA;
        else if (!holdWrHit) excCode = EXC_ADDR;
        else if (!holdWrOk) excCode = EXC_DATA;
        else rdData = reqData;
      FN_VENDOR: begin
        if (req.sub == SUB_LED_RD) begin
          if (req.nbytes != LED_RD_LEN) excCode = EXC_DATA;
          else rdData = {ledChan_r, ledFmt_r};
        end else if (req.sub == SUB_LED_WR) begin
          if (!ledWrOk) excCode = EXC_DATA;
          else rdData = 16'h0000;
        end else excCode = EXC_FUNC;
      end
      default: excCode = EXC_FUNC;
    endcase
  end
  // answer frame: echo codes, or flag the function as exception
  assign rspNxt.func = (excCode != 8'h00) ? (req.func | FN_EXC_BIT) :
                       req.func;
  assign rspNxt.sub = req.sub;
  assign rspNxt.data = rdData;
  assign rspNxt.exc = excCode;
  wire logic acc = reqValid && reqReady;
  wire logic ok = acc && excCode == 8'h00;
  wire logic wrCoil = ok && req.func == FN_WR_COIL;
  wire logic wrReg = ok &&
    (req.func == FN_WR_REG || req.func == FN_WR_MULTI);
  wire logic wrLed = ok && req.func == FN_VENDOR && req.sub == SUB_LED_WR;
  wire logic calStart = wrCoil && reqAddr == A_CAL && coilOn;
  wire logic wdtFire = !fired_r && wdtEn_r && wdtVal_r != 16'h0000 &&
    !acc && tick_r == 32'(WDT_CYC_P - 1) &&
    (units_r + 8'h01) == wdtVal_r[7:0];
  wire logic flagClr = (wrCoil && reqAddr == A_WDT_FLAG && coilOn) ||
    (wdtMode_r && (wrCoil || wrReg));
  // requests held off while a response is pending or cal runs
  assign reqReady = state_r == ST_IDLE && !calBusy_r;
  assign rspValid = state_r == ST_WAIT && waitCnt_r == 32'h00000000;
  assign rsp = rsp_r;
  assign calBusy = calBusy_r;
  assign wdtTimeout = wdtFlag_r;
  assign cfg = '{protocolRtu: proto_r, filter50Hz: filter_r,
    engFormat: format_r, baudCode: serial_r[SER_BAUD_MSB:0],
    framing: serial_r[SER_FRAME_MSB:SER_FRAME_LSB],
    station: station_r[7:0], chanEnable: chEn_r[5:0],
    ledChan: ledChan_r, ledFmt: ledFmt_r};
  // response sequencer with programmable delay
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      state_r <= ST_IDLE;
      waitCnt_r <= 32'h00000000;
      rsp_r <= '0;
    end else begin
      unique case (state_r)
        ST_IDLE: if (acc) begin
          state_r <= ST_WAIT;
          waitCnt_r <= 32'(delay_r) * 32'(MS_CYC_P);
          rsp_r <= rspNxt;
        end
        ST_WAIT: if (waitCnt_r == 32'h00000000) state_r <= ST_IDLE;
          else waitCnt_r <= waitCnt_r - 32'h00000001;
      endcase
    end
  end
  // configuration coils
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      proto_r <= RST_PROTO;
      filter_r <= 1'b0;
      wdtMode_r <= 1'b0;
      wdtEn_r <= 1'b0;
      format_r <= 1'b0;
      openForce_r <= 1'b0;
    end else if (wrCoil) begin
      if (reqAddr == A_PROTO) proto_r <= coilOn;
      if (reqAddr == A_FILTER) filter_r <= coilOn;
      if (reqAddr == A_WDT_MODE) wdtMode_r <= coilOn;
      if (reqAddr == A_WDT_EN) wdtEn_r <= coilOn;
      if (reqAddr == A_FORMAT) format_r <= coilOn;
      if (reqAddr == A_OPEN_FORCE) openForce_r <= coilOn;
    end
  end
  // scalar holding registers and led settings
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      station_r <= RST_STATION;
      serial_r <= RST_SERIAL;
      delay_r <= RST_DELAY;
      wdtVal_r <= RST_WDT_VAL;
      chEn_r <= RST_CH_EN;
      ledChan_r <= 8'h00;
      ledFmt_r <= 8'h00;
    end else begin
      if (wrReg && reqAddr == A_STATION) station_r <= reqData;
      if (wrReg && reqAddr == A_SERIAL) serial_r <= reqData;
      if (wrReg && reqAddr == A_DELAY) delay_r <= reqData;
      if (wrReg && reqAddr == A_WDT_VAL) wdtVal_r <= reqData;
      if (wrReg && reqAddr == A_CH_EN) chEn_r <= reqData;
      if (wrLed) begin
        ledChan_r <= reqData[15:8];
        ledFmt_r <= reqData[7:0];
      end
    end
  end
  // per-channel type codes and offsets
  always_ff @(posedge ref_clk) begin
    for (int i = 0; i < NCH; i++) begin
      if (reset) begin
        typeCode_r[i] <= RST_TYPE;
        tempOfs_r[i] <= 16'h0000;
        resOfs_r[i] <= 16'h0000;
      end else if (wrReg) begin
        if (reqAddr == A_TYPE + 16'(i)) typeCode_r[i] <= reqData;
        if (reqAddr == A_TEMP_OFS + 16'(i)) tempOfs_r[i] <= reqData;
        if (reqAddr == A_RES_OFS + 16'(i)) resOfs_r[i] <= reqData;
      end
    end
  end
  // host watchdog: any accepted request restarts the timer
  always_ff @(posedge ref_clk) begin
    if (reset || acc || !wdtEn_r || wdtVal_r == 16'h0000) begin
      tick_r <= 32'h00000000;
      units_r <= 8'h00;
      fired_r <= 1'b0;
    end else if (!fired_r) begin
      if (tick_r == 32'(WDT_CYC_P - 1)) begin
        tick_r <= 32'h00000000;
        units_r <= units_r + 8'h01;
        if (wdtFire) fired_r <= 1'b1;
      end else tick_r <= tick_r + 32'h00000001;
    end
  end
  // timeout flag and count; a new timeout beats a clear
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      wdtFlag_r <= 1'b0;
      wdtCnt_r <= 16'h0000;
    end else begin
      if (wdtFire) wdtFlag_r <= 1'b1;
      else if (flagClr) wdtFlag_r <= 1'b0;
      if (wdtFire) wdtCnt_r <= (wdtCnt_r == 16'hffff) ? wdtCnt_r :
                               wdtCnt_r + 16'h0001;
      else if (wrReg && reqAddr == A_WDT_CNT)
        wdtCnt_r <= 16'h0000;
    end
  end
  // calibration reload busy timer and first-read flag
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      calBusy_r <= 1'b0;
      calCnt_r <= 32'h00000000;
      firstRead_r <= 1'b1;
    end else begin
      if (calStart) begin
        calBusy_r <= 1'b1;
        calCnt_r <= 32'(CAL_CYC_P - 1);
      end else if (calBusy_r) begin
        if (calCnt_r == 32'h00000000) calBusy_r <= 1'b0;
        else calCnt_r <= calCnt_r - 32'h00000001;
      end
      if (ok && req.func == FN_RD_COILS && reqAddr == A_FIRST)
        firstRead_r <= 1'b0;
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);
  sequence s_ledRdAcc;
    acc && req.func == FN_VENDOR && req.sub == SUB_LED_RD &&
    req.nbytes == LED_RD_LEN;
  endsequence
  sequence s_ledBadAcc;
    acc && req.func == FN_VENDOR && req.sub == SUB_LED_WR && !ledWrOk;
  endsequence
  property p_ledRead;
    s_ledRdAcc |=> rsp.func == FN_VENDOR && rsp.sub == SUB_LED_RD &&
      rsp.data == {ledChan_r, ledFmt_r};
  endproperty
  a_ledRead: assert property (p_ledRead) else $error("led read bad");
  property p_ledChan;
    ledChan_r <= LED_CH_MAX;
  endproperty
  a_ledChan: assert property (p_ledChan) else $error("led chan");
  property p_ledFmt;
    wrLed |=> ledFmt_r == $past(reqData[7:0]) && ledFmt_r <= LED_FMT_MAX;
  endproperty
  a_ledFmt: assert property (p_ledFmt) else $error("led fmt");
  property p_ledWrite;
    wrLed |=> rsp.func == FN_VENDOR && rsp.sub == SUB_LED_WR &&
      rsp.data == 16'h0000;
  endproperty
  a_ledWrite: assert property (p_ledWrite) else $error("led wr");
  property p_ledExc;
    s_ledBadAcc |=> rsp.func == FN_VENDOR_EXC && rsp.exc == EXC_DATA &&
      $stable(ledChan_r);
  endproperty
  a_ledExc: assert property (p_ledExc) else $error("led exc");
  property p_station;
    station_r >= STATION_MIN && station_r <= STATION_MAX;
  endproperty
  a_station: assert property (p_station) else $error("station");
  property p_delay;
    acc && delay_r == 16'h0000 |=> rspValid ##1 !rspValid;
  endproperty
  a_delay: assert property (p_delay) else $error("delay zero");
  property p_wdtFlag;
    wdtFire |=> wdtFlag_r && wdtCnt_r != 16'h0000;
  endproperty
  a_wdtFlag: assert property (p_wdtFlag) else $error("wdt flag");
  property p_firstRead;
    ok && req.func == FN_RD_COILS && reqAddr == A_FIRST && firstRead_r
      |=> !firstRead_r && rsp.data == 16'h0001 ##1 !firstRead_r[*2];
  endproperty
  a_firstRead: assert property (p_firstRead) else $error("first");
  property p_maxRegs;
    acc && req.func == FN_WR_MULTI && req.qty > MAX_WR_REGS
      |=> rsp.exc == EXC_DATA && $stable(station_r);
  endproperty
  a_maxRegs: assert property (p_maxRegs) else $error("max regs");
  property p_calBusy;
    calStart |=> calBusy && !reqReady;
  endproperty
  a_calBusy: assert property (p_calBusy) else $error("cal busy");
endmodule

/* File: rtl/rtd_pkg.sv */
// Purpose: constants and types for the rtd module register bank
// Assumes: requests arrive already framed, one register per request
// Notes: one clock, synchronous active-high reset
// Overview of operation
// - LED read: codes 0x46/0x31, channel and format
// - LED channel byte valid 0x00 to 0x02
// - LED format: units, percent span, hex, ohms
// - LED write 0x32 echoes codes, result zero
// - bad LED request answers 0xC6, code 03
// - station address register holds 1 to 247
// - serial bits 5:0 baud codes 0x03-0x0A
// - serial bits 7:6 select parity and stops
// - response delayed by 0 to 30 ms
// - watchdog enable coil, timeout 0-255 tenths
// - timeout count clears by 0, flag W1C
// - mode coil lets output writes clear flag
// - protocol coil: 0 vendor ascii, 1 rtu
// - filter coil: 0 rejects 60Hz, 1 50Hz
// - format coil: 0 hex, 1 engineering
// - writing 1 reloads calibration, about 3 s
// - reset coil reads 1 once after power-on
// - force coil reports 32767 on open wire
// - at most eleven registers per write
// - per-channel temperature and resistance offsets, ranged
// - read-only range status and input values
// - under range -32768, over range +32767
package rtd_pkg;
  localparam int NCH = 6;
  // function and sub-function codes
  localparam logic [7:0] FN_RD_COILS = 8'h01;
  localparam logic [7:0] FN_RD_INPUTS = 8'h02;
  localparam logic [7:0] FN_RD_HOLD = 8'h03;
  localparam logic [7:0] FN_RD_INREG = 8'h04;
  localparam logic [7:0] FN_WR_COIL = 8'h05;
  localparam logic [7:0] FN_WR_REG = 8'h06;
  localparam logic [7:0] FN_WR_MULTI = 8'h10;
  localparam logic [7:0] FN_VENDOR = 8'h46;
  localparam logic [7:0] FN_VENDOR_EXC = 8'hc6;
  localparam logic [7:0] FN_EXC_BIT = 8'h80;
  localparam logic [7:0] SUB_LED_RD = 8'h31;
  localparam logic [7:0] SUB_LED_WR = 8'h32;
  localparam logic [7:0] EXC_FUNC = 8'h01;
  localparam logic [7:0] EXC_ADDR = 8'h02;
  localparam logic [7:0] EXC_DATA = 8'h03;
  localparam logic [7:0] LED_RD_LEN = 8'h03;
  localparam logic [7:0] LED_WR_LEN = 8'h05;
  localparam logic [7:0] LED_CH_MAX = 8'h02;
  localparam logic [7:0] LED_FMT_MAX = 8'h03;
  localparam logic [7:0] MAX_WR_REGS = 8'h0b;
  localparam logic [15:0] COIL_ON = 16'hff00;
  localparam logic [15:0] COIL_OFF = 16'h0000;
  // address map
  localparam logic [15:0] A_OVR_COIL = 16'h0081;
  localparam logic [15:0] A_PROTO = 16'h0101;
  localparam logic [15:0] A_FILTER = 16'h0103;
  localparam logic [15:0] A_WDT_MODE = 16'h0104;
  localparam logic [15:0] A_WDT_EN = 16'h0105;
  localparam logic [15:0] A_FORMAT = 16'h010d;
  localparam logic [15:0] A_WDT_FLAG = 16'h010e;
  localparam logic [15:0] A_CAL = 16'h0110;
  localparam logic [15:0] A_FIRST = 16'h0111;
  localparam logic [15:0] A_OPEN_FORCE = 16'h0113;
  localparam logic [15:0] A_OVR_INPUT = 16'h2791;
  localparam logic [15:0] A_AIN = 16'h7531;
  localparam logic [15:0] A_AIN_MIRROR = 16'h9c41;
  localparam logic [15:0] A_TYPE = 16'h9d41;
  localparam logic [15:0] A_TEMP_OFS = 16'h9d61;
  localparam logic [15:0] A_RES_OFS = 16'h9dc1;
  localparam logic [15:0] A_FW_LO = 16'h9e21;
  localparam logic [15:0] A_FW_HI = 16'h9e22;
  localparam logic [15:0] A_NAME_LO = 16'h9e23;
  localparam logic [15:0] A_NAME_HI = 16'h9e24;
  localparam logic [15:0] A_STATION = 16'h9e25;
  localparam logic [15:0] A_SERIAL = 16'h9e26;
  localparam logic [15:0] A_DELAY = 16'h9e28;
  localparam logic [15:0] A_WDT_VAL = 16'h9e29;
  localparam logic [15:0] A_CH_EN = 16'h9e2a;
  localparam logic [15:0] A_WDT_CNT = 16'h9e2c;
  // value limits and fields
  localparam logic [15:0] STATION_MIN = 16'h0001;
  localparam logic [15:0] STATION_MAX = 16'h00f7;
  localparam logic [5:0] BAUD_MIN = 6'h03;
  localparam logic [5:0] BAUD_MAX = 6'h0a;
  localparam int SER_BAUD_MSB = 5;
  localparam int SER_FRAME_LSB = 6;
  localparam int SER_FRAME_MSB = 7;
  localparam logic [15:0] DELAY_MAX = 16'h001e;
  localparam logic [15:0] BYTE_MAX = 16'h00ff;
  localparam logic [15:0] CH_EN_MAX = 16'h003f;
  localparam logic [15:0] VAL_OVER = 16'h7fff;
  localparam logic [15:0] VAL_UNDER = 16'h8000;
  // reset values
  localparam logic [15:0] RST_STATION = 16'h0001;
  localparam logic [15:0] RST_SERIAL = 16'h0006;
  localparam logic [15:0] RST_DELAY = 16'h0000;
  localparam logic [15:0] RST_WDT_VAL = 16'h0000;
  localparam logic [15:0] RST_CH_EN = 16'h003f;
  localparam logic [15:0] RST_TYPE = 16'h0020;
  localparam logic RST_PROTO = 1'b1;
  // timing
  localparam int CLK_PERIOD_NS = 20;
  localparam int MS_NS = 1000000;
  localparam int WDT_UNIT_MS = 100;
  localparam int CAL_TIME_MS = 3000;
  localparam int MS_CYC = (MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WDT_UNIT_CYC = WDT_UNIT_MS * MS_CYC;
  localparam int CAL_CYC = CAL_TIME_MS * MS_CYC;

  typedef struct packed {
    logic [7:0] func;
    logic [7:0] sub;
    logic [15:0] addr;
    logic [15:0] data;
    logic [7:0] qty;
    logic [7:0] nbytes;
  } rtd_req_t;

  typedef struct packed {
    logic [7:0] func;
    logic [7:0] sub;
    logic [15:0] data;
    logic [7:0] exc;
  } rtd_rsp_t;

  typedef struct packed {
    logic protocolRtu;
    logic filter50Hz;
    logic engFormat;
    logic [5:0] baudCode;
    logic [1:0] framing;
    logic [7:0] station;
    logic [5:0] chanEnable;
    logic [7:0] ledChan;
    logic [7:0] ledFmt;
  } rtd_cfg_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_WAIT = 2'b10
  } rtd_state_t;
endpackage

/* File: dv/rtd_host_model.sv */
// Purpose: modbus host model, one request at a time
// Assumes: bank takes a request when reqReady is high
// Notes: drives on the falling edge, bounded waits
`timescale 1ns/100ps
module rtd_host_model
  import rtd_pkg::*;
(
  input wire logic ref_clk,
  output logic reqValid,
  output rtd_req_t req,
  input wire logic reqReady,
  input wire logic rspValid,
  input wire rtd_rsp_t rsp,
  output rtd_rsp_t got,
  output int lat
);
  // hold the request until taken, then wait for the answer
  task automatic xfer(input rtd_req_t q);
    int n;
    n = 0;
    @(negedge ref_clk);
    req = q;
    reqValid = 1'b1;
    while (reqReady !== 1'b1 && n < 400) begin
      @(negedge ref_clk);
      n++;
    end
    @(negedge ref_clk);
    reqValid = 1'b0;
    req = ~q; // driven to the inverse of the request, no stale value
    lat = 1;
    while (rspValid !== 1'b1 && lat < 400) begin
      @(negedge ref_clk);
      lat++;
    end
    got = rsp;
  endtask
  // idle until the first request
  initial begin
    reqValid = 1'b0;
    req = '0;
  end
endmodule

/* File: dv/tb_rtd_modbus_regs.sv */
// Purpose: self-checking bench for the rtd register bank
// Assumes: 4 cycles per ms, watchdog unit 3, reload 10
// Notes: requests go through the host model
`timescale 1ns/100ps
module tb_rtd_modbus_regs
  import rtd_pkg::*;
;
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic reqValid, reqReady, rspValid, calBusy, wdtTimeout;
  rtd_req_t req;
  rtd_rsp_t rsp, got;
  rtd_cfg_t cfg;
  int lat;
  logic [NCH-1:0][15:0] adcValue = '0;
  logic [NCH-1:0] overRange = '0, underRange = '0, openWire = '0;
  int errors = 0, n_compared = 0, cyc = 0;
  localparam logic [39:0] T [12] = '{{A_STATION, 16'h0000, 8'h03},
    {A_STATION, 16'h00f8, 8'h03}, {A_STATION, 16'h00f7, 8'h00},
    {A_SERIAL, 16'h0002, 8'h03}, {A_SERIAL, 16'h000b, 8'h03},
    {A_SERIAL, 16'h00ca, 8'h00}, {A_DELAY, 16'h001f, 8'h03},
    {A_TEMP_OFS, 16'h0080, 8'h03}, {A_TEMP_OFS, 16'hff80, 8'h00},
    {A_RES_OFS, 16'h0100, 8'h03}, {A_RES_OFS, 16'h00ff, 8'h00},
    {16'h9e27, 16'h0000, 8'h02}};
  localparam logic [31:0] LB [4] = '{{SUB_LED_WR, 16'h0300, LED_WR_LEN},
    {SUB_LED_WR, 16'h0004, LED_WR_LEN}, {SUB_LED_WR, 16'h0101, 8'h04},
    {SUB_LED_RD, 16'h0000, 8'h02}};
  // clock and instances
  always #10 ref_clk = ~ref_clk;
  rtd_modbus_regs #(.MS_CYC_P(4), .WDT_CYC_P(3), .CAL_CYC_P(10))
    i_rtd_modbus_regs (.ref_clk, .reset, .reqValid, .req, .reqReady,
    .rspValid, .rsp, .adcValue, .overRange, .underRange, .openWire,
    .cfg, .calBusy, .wdtTimeout);
  rtd_host_model i_rtd_host_model (.ref_clk, .reqValid, .req, .reqReady,
    .rspValid, .rsp, .got, .lat);
  // compare, request and exception helpers
  task automatic ck(input logic [15:0] g, e);
    n_compared++;
    if (g !== e) begin
      errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic x(input logic [7:0] f, s, input logic [15:0] a, d,
    input logic [7:0] q = 8'h01, nb = 8'h00);
    i_rtd_host_model.xfer('{f, s, a, d, q, nb});
    if (lat >= 400) errors++; // bounded wait ran out
  endtask
  task automatic ex(input logic [7:0] f, input logic [15:0] a, d,
    input logic [7:0] e);
    x(f, 8'h00, a, d);
    ck({8'h00, got.exc}, {8'h00, e});
  endtask
  task automatic rd(input logic [7:0] f, input logic [15:0] a, e);
    x(f, 8'h00, a, 16'h0000);
    ck(got.data, e);
  endtask
  task automatic summarize;
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // hang guard
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      summarize();
    end
  end
  // main sequence
  initial begin
    repeat (6) @(posedge ref_clk);
    @(negedge ref_clk) reset = 1'b0;
    rd(FN_RD_COILS, A_FIRST, 16'h0001);
    rd(FN_RD_COILS, A_FIRST, 16'h0000);
    rd(FN_RD_HOLD, A_SERIAL, RST_SERIAL);
    ex(8'h07, A_STATION, 16'h0000, EXC_FUNC);
    $display("test reset done");
    foreach (T[i]) ex(FN_WR_REG, T[i][39:24], T[i][23:8], T[i][7:0]);
    rd(FN_RD_HOLD, A_STATION, 16'h00f7);
    rd(FN_RD_HOLD, A_TEMP_OFS, 16'hff80);
    ck({cfg.station, cfg.baudCode, cfg.framing}, 16'hf72b);
    ex(FN_WR_REG, A_AIN, 16'h0000, EXC_ADDR);
    $display("test ranges done");
    for (int c = 0; c < 3; c++) begin
      for (int f = 0; f < 4; f++) begin
        x(FN_VENDOR, SUB_LED_WR, 16'h0, {c[7:0], f[7:0]}, 8'h01,
          LED_WR_LEN);
        ck({got.exc, got.data[7:0]}, 16'h0000);
        x(FN_VENDOR, SUB_LED_RD, 16'h0, 16'h0, 8'h01, LED_RD_LEN);
        ck(got.data, {c[7:0], f[7:0]});
        ck({got.func, got.sub}, 16'h4631);
      end
    end
    foreach (LB[i]) begin
      x(FN_VENDOR, LB[i][31:24], 16'h0, LB[i][23:8], 8'h01, LB[i][7:0]);
      ck({got.func, got.exc}, 16'hc603);
    end
    ck({cfg.ledChan, cfg.ledFmt}, 16'h0203);
    $display("test led done");
    @(negedge ref_clk);
    adcValue[0] = 16'h1234;
    overRange[1] = 1'b1;
    underRange[2] = 1'b1;
    openWire[3] = 1'b1;
    rd(FN_RD_INREG, A_AIN, 16'h1234);
    rd(FN_RD_HOLD, A_AIN_MIRROR, 16'h1234);
    rd(FN_RD_INREG, A_AIN + 16'h1, VAL_OVER);
    rd(FN_RD_INREG, A_AIN + 16'h2, VAL_UNDER);
    rd(FN_RD_INPUTS, A_OVR_INPUT + 16'h1, 16'h0001);
    rd(FN_RD_INPUTS, A_OVR_INPUT, 16'h0000);
    ex(FN_WR_COIL, A_OPEN_FORCE, COIL_ON, 8'h00);
    rd(FN_RD_INREG, A_AIN + 16'h3, VAL_OVER);
    $display("test analog done");
    ex(FN_WR_COIL, A_PROTO, COIL_OFF, 8'h00);
    ex(FN_WR_COIL, A_FILTER, COIL_ON, 8'h00);
    ex(FN_WR_COIL, A_FORMAT, COIL_ON, 8'h00);
    ex(FN_WR_COIL, A_FORMAT, 16'h1234, EXC_DATA);
    ck({cfg.protocolRtu, cfg.filter50Hz, cfg.engFormat}, 16'h3);
    rd(FN_RD_COILS, A_FILTER, 16'h0001);
    ex(FN_WR_REG, A_DELAY, 16'h001e, 8'h00);
    rd(FN_RD_HOLD, A_DELAY, 16'h001e);
    ck(lat[15:0], 16'd121);
    ex(FN_WR_REG, A_DELAY, 16'h0000, 8'h00);
    rd(FN_RD_HOLD, A_DELAY, 16'h0000);
    ck(lat[15:0], 16'd1);
    $display("test coils done");
    ex(FN_WR_REG, A_WDT_VAL, 16'h0002, 8'h00);
    ex(FN_WR_COIL, A_WDT_EN, COIL_ON, 8'h00);
    repeat (12) @(negedge ref_clk);
    ck(wdtTimeout, 16'h1);
    rd(FN_RD_HOLD, A_WDT_CNT, 16'h0001);
    ex(FN_WR_REG, A_WDT_CNT, 16'h0005, EXC_DATA);
    ex(FN_WR_REG, A_WDT_CNT, 16'h0000, 8'h00);
    rd(FN_RD_HOLD, A_WDT_CNT, 16'h0000);
    ck(wdtTimeout, 16'h1);
    ex(FN_WR_COIL, A_WDT_FLAG, COIL_ON, 8'h00);
    ck(wdtTimeout, 16'h0);
    ex(FN_WR_COIL, A_WDT_MODE, COIL_ON, 8'h00);
    repeat (12) @(negedge ref_clk);
    ck(wdtTimeout, 16'h1);
    ex(FN_WR_REG, A_CH_EN, 16'h003f, 8'h00);
    ck(wdtTimeout, 16'h0);
    ex(FN_WR_REG, A_WDT_VAL, 16'h0000, 8'h00);
    $display("test watchdog done");
    x(FN_WR_MULTI, 8'h00, A_TYPE, 16'h0021, 8'd12);
    ck({8'h00, got.exc}, 16'h0003);
    x(FN_WR_MULTI, 8'h00, A_TYPE, 16'h0021, 8'd11);
    ck({8'h00, got.exc}, 16'h0000);
    ex(FN_WR_COIL, A_CAL, COIL_ON, 8'h00);
    ck({reqReady, calBusy}, 16'h1);
    rd(FN_RD_HOLD, A_TYPE, 16'h0021);
    ck(calBusy, 16'h0);
    $display("test multi and reload done");
    summarize();
  end
endmodule
